// ---- hdl/dso_regs.svh ----
/*
 * Constants for the drive status output encoder: output function codes,
 * alarm class codes, restart modes and timing counts.
 * Assumes a 200 MHz system clock; included by bare name from the hdl/ files.
 */
// Contract
// - terminal stop input OFF forces drive stop
// - assigned terminal stop ignores communication stop command
// - base code normal, base plus 1000 inverted
// - stage change gives one 100 ms pulse
// - seven stages done give one 100 ms pulse
// - current stage shown as binary 1-2-4 code
// - pattern outputs unavailable in torque control
// - sync flag while target inside angle window
// - bus low flag below detect level, hysteresis-free; code holds the flag while bus voltage equals detect level
// - modes 2/3: flag below running level, clear +10V
// - modes 4/5: flag on undervoltage, clear +10V
// - alarm classes 1 to 7 on 4-bit code
// - alarm classes 8 to 15 on 4-bit code
// - alarm code zero while no protection active; code shows the charger class while a safety fault is latched
// - both safety inputs open: flag, torque off
// - safety inputs disagree 50 ms: sticky fault
`ifndef DSO_REGS_SVH
`define DSO_REGS_SVH

// output function base codes and inversion offset
`define DSO_FN_INV 11'h3e8
`define DSO_FN_STAGE_TRANS 11'h010
`define DSO_FN_CYCLE_DONE 11'h011
`define DSO_FN_STAGE_B0 11'h012
`define DSO_FN_STAGE_B1 11'h013
`define DSO_FN_STAGE_B2 11'h014
`define DSO_FN_SYNC_DONE 11'h01d
`define DSO_FN_BUS_LOW 11'h04d
`define DSO_FN_PF_DECEL 11'h04f
`define DSO_FN_ALARM_B0 11'h05a
`define DSO_FN_ALARM_B1 11'h05b
`define DSO_FN_ALARM_B2 11'h05c
`define DSO_FN_ALARM_B3 11'h05d
`define DSO_FN_SAFETY_FAULT 11'h065
`define DSO_FN_ENABLE_OFF 11'h066
// input function code of the terminal-only forced stop
`define DSO_FN_FORCE_STOP 11'h06f

// pattern operation
`define DSO_STAGE_LAST 3'h7

// restart mode selections that drive the power failure flag
`define DSO_RESTART_CRL_A 3'h2
`define DSO_RESTART_CRL_B 3'h3
`define DSO_RESTART_UV_A 3'h4
`define DSO_RESTART_UV_B 3'h5
`define DSO_PF_HYST_V 11'h00a

// alarm class codes
`define DSO_AC_NONE 4'h0
`define DSO_AC_OVERCURRENT 4'h1
`define DSO_AC_OVERVOLT 4'h2
`define DSO_AC_UNDERVOLT 4'h3
`define DSO_AC_MOTOR_OL 4'h4
`define DSO_AC_DRIVE_OL 4'h5
`define DSO_AC_OVERHEAT 4'h6
`define DSO_AC_EXTERNAL 4'h7
`define DSO_AC_MEMORY 4'h8
`define DSO_AC_LINK 4'h9
`define DSO_AC_OPTION 4'ha
`define DSO_AC_CHARGER 4'hb
`define DSO_AC_TUNING 4'hc
`define DSO_AC_RS485 4'hd
`define DSO_AC_OVERSPEED 4'he
`define DSO_AC_WIRE_BREAK 4'hf

// timing
`define DSO_CLK_KHZ 200000
`define DSO_PULSE_MS 100
`define DSO_PULSE_CYC (`DSO_PULSE_MS * `DSO_CLK_KHZ)
`define DSO_DISC_MS 50
`define DSO_DISC_CYC (`DSO_DISC_MS * `DSO_CLK_KHZ)
`define DSO_N_TERM 6

`endif

// ---- hdl/dso_pkg.sv ----
/*
 * Types shared by the drive status output encoder files.
 * Assumes bus voltages arrive as whole volts in 10 bits.
 */
package dso_pkg;
    typedef logic [10:0] dso_fcode_t;
    typedef logic [9:0] dso_volt_t;

    // protective function currently active, none when running normally
    typedef enum logic [4:0] {
        ALM_NONE, ALM_OVERCURRENT, ALM_GROUND_FAULT, ALM_FUSE, ALM_OVERVOLT,
        ALM_UNDERVOLT, ALM_IN_PHASE, ALM_MOTOR_OL, ALM_DRIVE_OL, ALM_OVERHEAT,
        ALM_EXTERNAL, ALM_MEMORY, ALM_LINK, ALM_OPTION, ALM_CHARGER,
        ALM_TUNING, ALM_RS485, ALM_OVERSPEED, ALM_WIRE_BREAK
    } dso_alarm_t;

    typedef struct packed {
        dso_volt_t bus_voltage;
        dso_volt_t detect_level;
        dso_volt_t cont_level;
        dso_volt_t uv_level;
    } dso_levels_t;

    typedef struct packed {
        logic stage_transition_pulse;
        logic cycle_complete_pulse;
        logic stage_code_bit2;
        logic stage_code_bit1;
        logic stage_code_bit0;
        logic sync_complete_flag;
        logic bus_low_voltage_flag;
        logic power_fail_decel_flag;
        logic alarm_code_bit3;
        logic alarm_code_bit2;
        logic alarm_code_bit1;
        logic alarm_code_bit0;
        logic safety_circuit_fault_out;
        logic enable_off_flag;
    } dso_status_t;
endpackage

// ---- hdl/dso_oneshot.sv ----
/*
 * Retriggerable one-shot: a trigger starts a pulse of PULSE_CYC cycles.
 * Assumes trig is synchronous to clk.
 */
`timescale 1ns/1ps
`include "dso_regs.svh"
module dso_oneshot #(
    parameter int PULSE_CYC = `DSO_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic trig,
    output logic pulse
);
    localparam int CW = $clog2(PULSE_CYC + 1);

    generate
        if (PULSE_CYC < 1) begin : g_bad
            $error("dso_oneshot: PULSE_CYC must be at least 1");
        end
    endgenerate

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic next_pulse;

    // a new trigger restarts the full length, so back-to-back events stretch it
    always_comb begin
        if (trig) begin
            next_cnt = CW'(PULSE_CYC - 1);
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end else begin
            next_cnt = '0;
        end
        next_pulse = trig || (cnt != '0);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
            pulse <= 1'b0;
        end else begin
            cnt <= next_cnt;
            pulse <= next_pulse;
        end
    end
endmodule

// ---- hdl/dso_encoder.sv ----
/*
 * Drive status output encoder: pattern stage pulses and code, sync,
 * bus voltage and power failure flags, alarm class code, safety enable
 * monitoring, terminal-only forced stop and per-terminal function select.
 * Assumes all inputs except the three pins share clk; pins are synchronised.
 */
`timescale 1ns/1ps
`include "dso_regs.svh"
module dso_encoder import dso_pkg::*; #(
    parameter int N_TERM = `DSO_N_TERM,
    parameter int PULSE_CYC = `DSO_PULSE_CYC,
    parameter int DISC_CYC = `DSO_DISC_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire dso_fcode_t [N_TERM-1:0] term_func_sel,
    input wire dso_fcode_t stop_term_func,
    input wire logic stop_term_pin,
    input wire logic comm_stop_req,
    input wire logic safety_input_a,
    input wire logic safety_input_b,
    input wire logic torque_mode,
    input wire logic [2:0] pattern_stage,
    input wire logic sync_active,
    input wire logic sync_in_window,
    input wire dso_levels_t levels,
    input wire logic [2:0] restart_mode_select,
    input wire logic uv_alarm,
    input wire dso_alarm_t alarm_src,
    output logic [N_TERM-1:0] terminal_out,
    output dso_status_t status,
    output logic force_stop,
    output logic torque_shutdown
);
    localparam int DW = $clog2(DISC_CYC + 1);

    generate
        if (N_TERM < 1 || DISC_CYC < 1 || PULSE_CYC < 1) begin : g_bad
            $error("dso_encoder: N_TERM, DISC_CYC and PULSE_CYC must be at least 1");
        end
    endgenerate

    // strip the inversion offset; returns the base code
    function automatic dso_fcode_t fn_base(input dso_fcode_t code);
        fn_base = (code >= `DSO_FN_INV) ? dso_fcode_t'(code - `DSO_FN_INV) : code;
    endfunction

    // one terminal's level for its selected function
    function automatic logic fn_bit(input dso_fcode_t code, input dso_status_t s);
        logic v;
        v = 1'b0;
        case (fn_base(code))
            `DSO_FN_STAGE_TRANS: v = s.stage_transition_pulse;
            `DSO_FN_CYCLE_DONE: v = s.cycle_complete_pulse;
            `DSO_FN_STAGE_B0: v = s.stage_code_bit0;
            `DSO_FN_STAGE_B1: v = s.stage_code_bit1;
            `DSO_FN_STAGE_B2: v = s.stage_code_bit2;
            `DSO_FN_SYNC_DONE: v = s.sync_complete_flag;
            `DSO_FN_BUS_LOW: v = s.bus_low_voltage_flag;
            `DSO_FN_PF_DECEL: v = s.power_fail_decel_flag;
            `DSO_FN_ALARM_B0: v = s.alarm_code_bit0;
            `DSO_FN_ALARM_B1: v = s.alarm_code_bit1;
            `DSO_FN_ALARM_B2: v = s.alarm_code_bit2;
            `DSO_FN_ALARM_B3: v = s.alarm_code_bit3;
            `DSO_FN_SAFETY_FAULT: v = s.safety_circuit_fault_out;
            `DSO_FN_ENABLE_OFF: v = s.enable_off_flag;
            default: v = 1'b0;
        endcase
        fn_bit = v ^ (code >= `DSO_FN_INV);
    endfunction

    // protective function to alarm class
    function automatic logic [3:0] alarm_code(input dso_alarm_t a);
        case (a)
            ALM_OVERCURRENT, ALM_GROUND_FAULT, ALM_FUSE: alarm_code = `DSO_AC_OVERCURRENT;
            ALM_OVERVOLT: alarm_code = `DSO_AC_OVERVOLT;
            ALM_UNDERVOLT, ALM_IN_PHASE: alarm_code = `DSO_AC_UNDERVOLT;
            ALM_MOTOR_OL: alarm_code = `DSO_AC_MOTOR_OL;
            ALM_DRIVE_OL: alarm_code = `DSO_AC_DRIVE_OL;
            ALM_OVERHEAT: alarm_code = `DSO_AC_OVERHEAT;
            ALM_EXTERNAL: alarm_code = `DSO_AC_EXTERNAL;
            ALM_MEMORY: alarm_code = `DSO_AC_MEMORY;
            ALM_LINK: alarm_code = `DSO_AC_LINK;
            ALM_OPTION: alarm_code = `DSO_AC_OPTION;
            ALM_CHARGER: alarm_code = `DSO_AC_CHARGER;
            ALM_TUNING: alarm_code = `DSO_AC_TUNING;
            ALM_RS485: alarm_code = `DSO_AC_RS485;
            ALM_OVERSPEED: alarm_code = `DSO_AC_OVERSPEED;
            ALM_WIRE_BREAK: alarm_code = `DSO_AC_WIRE_BREAK;
            default: alarm_code = `DSO_AC_NONE;
        endcase
    endfunction

    // pin synchronisers; the first stage feeds only the second
    logic stop_meta, stop_s, ena_meta, ena_s, enb_meta, enb_s;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stop_meta <= 1'b1;
            stop_s <= 1'b1;
            ena_meta <= 1'b0;
            ena_s <= 1'b0;
            enb_meta <= 1'b0;
            enb_s <= 1'b0;
        end else begin
            stop_meta <= stop_term_pin;
            stop_s <= stop_meta;
            ena_meta <= safety_input_a;
            ena_s <= ena_meta;
            enb_meta <= safety_input_b;
            enb_s <= enb_meta;
        end
    end

    logic [2:0] stage_prev;
    logic stage_step, cycle_step, tu_pulse, to_pulse;

    // stage 0 means no pattern running, so entering or leaving is no transition
    assign stage_step = (pattern_stage != 3'h0) && (stage_prev != 3'h0) && (pattern_stage != stage_prev);
    assign cycle_step = (stage_prev == `DSO_STAGE_LAST) && (pattern_stage != `DSO_STAGE_LAST);

    dso_oneshot #(.PULSE_CYC(PULSE_CYC)) u_stage_shot (
        .clk(clk),
        .rst_b(rst_b),
        .trig(stage_step),
        .pulse(tu_pulse)
    );
    dso_oneshot #(.PULSE_CYC(PULSE_CYC)) u_cycle_shot (
        .clk(clk),
        .rst_b(rst_b),
        .trig(cycle_step),
        .pulse(to_pulse)
    );

    logic [DW-1:0] disc_cnt, next_disc_cnt;
    logic fault, next_fault;
    logic [2:0] next_stage_prev;
    dso_status_t next_status;
    logic [N_TERM-1:0] next_terminal_out;
    logic next_force_stop, next_torque_shutdown;
    logic stop_assigned;
    logic [10:0] v_bus, crl_hi, uv_hi;
    logic [3:0] ac;

    // next state of all flags, counters and terminals
    always_comb begin
        next_stage_prev = pattern_stage;
        stop_assigned = (fn_base(stop_term_func) == `DSO_FN_FORCE_STOP);
        // comm stop is dropped while the terminal owns the function
        if (stop_assigned) begin
            next_force_stop = (stop_s == (stop_term_func >= `DSO_FN_INV));
        end else begin
            next_force_stop = comm_stop_req;
        end
        // discrepancy timer; fault latches until power-on reset
        if (ena_s != enb_s) begin
            next_disc_cnt = (disc_cnt == DW'(DISC_CYC)) ? disc_cnt : disc_cnt + 1'b1;
        end else begin
            next_disc_cnt = '0;
        end
        next_fault = fault || ((ena_s != enb_s) && (disc_cnt == DW'(DISC_CYC - 1)));
        next_torque_shutdown = !(ena_s && enb_s) || next_fault;
        next_status = '0;
        next_status.enable_off_flag = !ena_s && !enb_s;
        next_status.safety_circuit_fault_out = next_fault;
        // pattern outputs exist only outside torque control
        if (!torque_mode) begin
            next_status.stage_transition_pulse = tu_pulse;
            next_status.cycle_complete_pulse = to_pulse;
            {next_status.stage_code_bit2, next_status.stage_code_bit1,
             next_status.stage_code_bit0} = pattern_stage;
            next_status.sync_complete_flag = sync_active && sync_in_window;
        end
        // undervoltage flag holds between the two sides of the level
        v_bus = {1'b0, levels.bus_voltage};
        if (levels.bus_voltage < levels.detect_level) begin
            next_status.bus_low_voltage_flag = 1'b1;
        end else if (levels.bus_voltage > levels.detect_level) begin
            next_status.bus_low_voltage_flag = 1'b0;
        end else begin
            next_status.bus_low_voltage_flag = status.bus_low_voltage_flag;
        end
        // widened sums so a level near full scale does not wrap
        crl_hi = {1'b0, levels.cont_level} + `DSO_PF_HYST_V;
        uv_hi = {1'b0, levels.uv_level} + `DSO_PF_HYST_V;
        next_status.power_fail_decel_flag = status.power_fail_decel_flag;
        case (restart_mode_select)
            `DSO_RESTART_CRL_A, `DSO_RESTART_CRL_B: begin
                if (levels.bus_voltage < levels.cont_level) begin
                    next_status.power_fail_decel_flag = 1'b1;
                end else if (v_bus > crl_hi) begin
                    next_status.power_fail_decel_flag = 1'b0;
                end
            end
            `DSO_RESTART_UV_A, `DSO_RESTART_UV_B: begin
                if (uv_alarm) begin
                    next_status.power_fail_decel_flag = 1'b1;
                end else if (v_bus > uv_hi) begin
                    next_status.power_fail_decel_flag = 1'b0;
                end
            end
            default: next_status.power_fail_decel_flag = 1'b0;
        endcase
        // a latched enable fault reports the charger class over any other alarm
        ac = next_fault ? `DSO_AC_CHARGER : alarm_code(alarm_src);
        {next_status.alarm_code_bit3, next_status.alarm_code_bit2,
         next_status.alarm_code_bit1, next_status.alarm_code_bit0} = ac;
        for (int i = 0; i < N_TERM; i++) begin
            next_terminal_out[i] = fn_bit(term_func_sel[i], next_status);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_prev <= 3'h0;
            disc_cnt <= '0;
            fault <= 1'b0;
            status <= '0;
            terminal_out <= '0;
            force_stop <= 1'b0;
            torque_shutdown <= 1'b1;
        end else begin
            stage_prev <= next_stage_prev;
            disc_cnt <= next_disc_cnt;
            fault <= next_fault;
            status <= next_status;
            terminal_out <= next_terminal_out;
            force_stop <= next_force_stop;
            torque_shutdown <= next_torque_shutdown;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_force_stop_term: assert property (
        fn_base(stop_term_func) == `DSO_FN_FORCE_STOP && stop_term_func < `DSO_FN_INV && !stop_s |=> force_stop)
        else $error("terminal stop off did not force stop");
    chk_comm_stop_ignored: assert property (
        stop_term_func == `DSO_FN_FORCE_STOP && stop_s && comm_stop_req |=> !force_stop)
        else $error("comm stop obeyed while terminal owns stop");
    // the last terminal carries the inverted code in the pattern scenario; skip the edge after reset
    chk_term_inverted: assert property (
        $past(rst_b) && $past(term_func_sel[N_TERM-1]) == `DSO_FN_STAGE_TRANS + `DSO_FN_INV |->
            terminal_out[N_TERM-1] == !status.stage_transition_pulse)
        else $error("inverted stage transition terminal wrong");
    chk_stage_pulse_out: assert property (
        stage_step && !torque_mode ##1 !torque_mode |=> status.stage_transition_pulse)
        else $error("stage change gave no transition pulse");
    chk_stage_pulse_cause: assert property (
        $rose(tu_pulse) |-> $past(stage_step))
        else $error("transition pulse without stage change");
    chk_cycle_pulse_out: assert property (
        cycle_step && !torque_mode ##1 !torque_mode |=> status.cycle_complete_pulse)
        else $error("cycle end gave no completion pulse");
    chk_stage_code: assert property (
        !torque_mode |=> {status.stage_code_bit2, status.stage_code_bit1,
                          status.stage_code_bit0} == $past(pattern_stage))
        else $error("stage code does not match stage");
    chk_torque_gating: assert property (
        torque_mode |=> !status.stage_transition_pulse && !status.cycle_complete_pulse &&
            !status.stage_code_bit0 && !status.stage_code_bit1 && !status.stage_code_bit2)
        else $error("pattern output active in torque control");
    chk_bus_low_set: assert property (
        levels.bus_voltage < levels.detect_level |=> status.bus_low_voltage_flag)
        else $error("bus low flag missing");
    chk_pf_hold: assert property (
        restart_mode_select == `DSO_RESTART_CRL_A && status.power_fail_decel_flag &&
            {1'b0, levels.bus_voltage} <= {1'b0, levels.cont_level} + `DSO_PF_HYST_V |=>
            status.power_fail_decel_flag)
        else $error("power fail flag cleared inside hysteresis");
    chk_alarm_none: assert property (
        alarm_src == ALM_NONE && !next_fault |=> {status.alarm_code_bit3, status.alarm_code_bit2,
            status.alarm_code_bit1, status.alarm_code_bit0} == `DSO_AC_NONE)
        else $error("alarm code active with no alarm");
    chk_enable_off: assert property (
        !ena_s && !enb_s |=> status.enable_off_flag && torque_shutdown)
        else $error("both enables open without shutdown");
    chk_fault_sticky: assert property (
        fault |=> fault && status.safety_circuit_fault_out)
        else $error("safety fault cleared without reset");

    cov_stage_pulse: cover property (stage_step && !torque_mode);
    cov_cycle_done: cover property (cycle_step);
    cov_pf_set: cover property ($rose(status.power_fail_decel_flag));
    cov_safety_fault: cover property ($rose(fault));
endmodule

// ---- dv/dso_relay_model.sv ----
/*
 * Relay-side model: reads the terminal outputs as a PLC input card would,
 * counting on-transitions and the length of the last completed on-time.
 * Assumes terminals are sampled on the rising edge of the shared clock.
 */
`timescale 1ns/1ps
module dso_relay_model #(
    parameter int N = 6
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [N-1:0] term,
    output int rises [N],
    output int width [N]
);
    int run [N];

    // count on-time per terminal; a relay only sees whole cycles, so widths are in cycles
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rises <= '{default: 0};
            width <= '{default: 0};
            run <= '{default: 0};
        end else begin
            for (int i = 0; i < N; i++) begin
                if (term[i]) begin
                    run[i] <= run[i] + 1;
                    if (run[i] == 0) rises[i] <= rises[i] + 1; // one-shot start
                end else if (run[i] > 0) begin
                    width[i] <= run[i];
                    run[i] <= 0;
                end
            end
        end
    end
endmodule

// ---- dv/drive_status_output_encoder_bench.sv ----
/*
 * Self-checking bench for the status output encoder with a reference model.
 * Assumes short pulse and discrepancy counts; inputs change on falling edges.
 */
`timescale 1ns/1ps
`include "dso_regs.svh"
module drive_status_output_encoder_bench import dso_pkg::*;;
    localparam int PC = 8;
    localparam int DC = 5;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    dso_fcode_t [5:0] sel = '0;
    dso_fcode_t stf = '0;
    logic pin = 1'b1, cst = 1'b0, sa = 1'b1, sb = 1'b1, tq = 1'b0, sy_a = 1'b0, sy_w = 1'b0, uv = 1'b0;
    logic [2:0] stg = 3'h0, rm = 3'h0;
    dso_levels_t lv = '0;
    dso_alarm_t al = ALM_NONE;
    logic [5:0] tout;
    dso_status_t st;
    logic fs, tsd;
    int rises [6], width [6];
    int miscompares = 0, checks_done = 0, seed = 91, i, lowx = 0, pfx = 0, r0 = 0, r1 = 0;
    int cls [19] = '{0, 1, 1, 1, 2, 3, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};

    dso_encoder #(.N_TERM(6), .PULSE_CYC(PC), .DISC_CYC(DC)) dut (
        .clk(clk), .rst_b(rst_b), .term_func_sel(sel), .stop_term_func(stf), .stop_term_pin(pin),
        .comm_stop_req(cst), .safety_input_a(sa), .safety_input_b(sb), .torque_mode(tq),
        .pattern_stage(stg), .sync_active(sy_a), .sync_in_window(sy_w), .levels(lv),
        .restart_mode_select(rm), .uv_alarm(uv), .alarm_src(al), .terminal_out(tout),
        .status(st), .force_stop(fs), .torque_shutdown(tsd));
    dso_relay_model #(.N(6)) relay (.clk(clk), .rst_b(rst_b), .term(tout), .rises(rises), .width(width));

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    task step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // four-state compare so an unknown never matches
    task chk(input logic [15:0] g, input logic [15:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #100000;
        miscompares++;
        end_sim;
    end

    initial begin
        step(8);
        rst_b = 1'b1;
        // alarm classes through normal and inverted terminals
        sel = {`DSO_FN_ALARM_B3 + `DSO_FN_INV, `DSO_FN_ALARM_B0 + `DSO_FN_INV, `DSO_FN_ALARM_B3,
               `DSO_FN_ALARM_B2, `DSO_FN_ALARM_B1, `DSO_FN_ALARM_B0};
        for (i = 0; i < 19; i++) begin
            al = dso_alarm_t'(i);
            step(1);
            chk({st.alarm_code_bit3, st.alarm_code_bit2, st.alarm_code_bit1, st.alarm_code_bit0}, cls[i][3:0], "alarm code");
            chk(tout, {~cls[i][3], ~cls[i][0], cls[i][3:0]}, "alarm terminals");
        end
        al = ALM_NONE;
        $display("alarm test done");
        // random bus voltages against both hysteresis models
        lv.cont_level = 10'h190;
        lv.uv_level = 10'h12c;
        for (i = 0; i < 300; i++) begin
            rm = 3'h2 + 3'({$random(seed)} % 4);
            lv.bus_voltage = 10'(290 + {$random(seed)} % 130);
            lv.detect_level = 10'(lv.bus_voltage + {$random(seed)} % 3 - 1);
            uv = 1'($random(seed));
            if (lv.bus_voltage < lv.detect_level) lowx = 1;
            else if (lv.bus_voltage > lv.detect_level) lowx = 0;
            if (rm < 3'h4) begin
                if (lv.bus_voltage < lv.cont_level) pfx = 1;
                else if (lv.bus_voltage > lv.cont_level + 10) pfx = 0;
            end else begin
                if (uv) pfx = 1;
                else if (lv.bus_voltage > lv.uv_level + 10) pfx = 0;
            end
            step(1);
            chk(st.bus_low_voltage_flag, lowx[0], "bus low flag");
            chk(st.power_fail_decel_flag, pfx[0], "power fail flag");
        end
        rm = 3'h0;
        uv = 1'b1;
        step(1);
        chk(st.power_fail_decel_flag, 1'b0, "power fail other mode");
        uv = 1'b0;
        $display("voltage test done");
        // full pattern cycle, one stage every 21 cycles so pulses complete
        // relay counts already hold edges of the alarm test, so count from here
        r0 = rises[0];
        r1 = rises[1];
        sel = {`DSO_FN_STAGE_TRANS + `DSO_FN_INV, `DSO_FN_STAGE_B2, `DSO_FN_STAGE_B1, `DSO_FN_STAGE_B0,
               `DSO_FN_CYCLE_DONE, `DSO_FN_STAGE_TRANS};
        for (i = 1; i <= 8; i++) begin
            stg = 3'(i == 8 ? 1 : i);
            step(1);
            chk({st.stage_code_bit2, st.stage_code_bit1, st.stage_code_bit0}, stg, "stage code");
            chk(tout[4:2], stg, "stage terminals");
            step(20);
        end
        chk(16'(rises[0] - r0), 16'h0007, "transition count");
        chk(width[0][15:0], PC[15:0], "transition width");
        chk(16'(rises[1] - r1), 16'h0001, "cycle count");
        chk(width[1][15:0], PC[15:0], "cycle width");
        chk(tout[5], 1'b1, "inverted idle");
        sy_a = 1'b1;
        sy_w = 1'b1;
        step(1);
        chk(st.sync_complete_flag, 1'b1, "sync in window");
        sy_w = 1'b0;
        step(1);
        chk(st.sync_complete_flag, 1'b0, "sync out of window");
        sy_w = 1'b1;
        tq = 1'b1;
        stg = 3'h2;
        step(1);
        chk({st.stage_code_bit2, st.stage_code_bit1, st.stage_code_bit0, st.sync_complete_flag}, 4'h0, "torque mode");
        step(20);
        chk(16'(rises[0] - r0), 16'h0007, "torque no pulse");
        $display("pattern test done");
        // terminal-only stop against the communication command
        stf = `DSO_FN_FORCE_STOP;
        cst = 1'b1;
        step(4);
        chk(fs, 1'b0, "comm stop ignored");
        pin = 1'b0;
        step(4);
        chk(fs, 1'b1, "terminal off stops");
        pin = 1'b1;
        step(4);
        chk(fs, 1'b0, "terminal on runs");
        // inverted assignment stops while the pin is on
        stf = `DSO_FN_FORCE_STOP + `DSO_FN_INV;
        step(1);
        chk(fs, 1'b1, "inverted terminal on stops");
        pin = 1'b0;
        step(4);
        chk(fs, 1'b0, "inverted terminal off runs");
        pin = 1'b1;
        stf = 11'h000;
        step(1);
        chk(fs, 1'b1, "comm stop when unassigned");
        cst = 1'b0;
        $display("stop test done");
        // safety enables: open, short and long disagreement, sticky fault
        step(4);
        chk({st.enable_off_flag, tsd}, 2'b00, "enables closed");
        sa = 1'b0;
        sb = 1'b0;
        step(4);
        chk({st.enable_off_flag, tsd}, 2'b11, "enables open");
        sb = 1'b1;
        step(DC - 2);
        sa = 1'b1;
        step(6);
        chk(st.safety_circuit_fault_out, 1'b0, "short disagreement");
        sa = 1'b0;
        for (i = 0; i < 40 && st.safety_circuit_fault_out !== 1'b1; i++) step(1);
        chk(16'(i), 16'(DC + 2), "fault delay");
        if (i == 40) end_sim;
        sa = 1'b1;
        step(4);
        chk({st.safety_circuit_fault_out, tsd, st.alarm_code_bit3, st.alarm_code_bit2, st.alarm_code_bit1, st.alarm_code_bit0},
            6'h3b, "fault sticky");
        rst_b = 1'b0;
        step(2);
        chk(tsd, 1'b1, "shutdown in reset");
        rst_b = 1'b1;
        step(4);
        chk({st.safety_circuit_fault_out, tsd}, 2'b00, "fault cleared by reset");
        $display("safety test done");
        end_sim;
    end
endmodule
